// ==== tlelm_lane.sv ====
`timescale 1ns/1ps
// One processor byte lane steered onto its PCI dword and byte position.
module tlelm_lane
  import tlelm_pkg::*;
#(
  parameter int LANE = 0
)(
  input  wire logic [7:0] lane_data_i,
  input  wire logic       lane_en_i,
  output logic            dw_sel_o,
  output logic [1:0]      pos_o,
  output logic [7:0]      data_o,
  output logic            en_o
);

  // ==========================================================================
  // Data-invariant steering
  // ==========================================================================
  localparam int POS = (TLELM_DW_LANES - 1) - (LANE % TLELM_DW_LANES);

  assign dw_sel_o = (LANE >= TLELM_DW_LANES);
  assign pos_o    = 2'(POS);
  assign data_o   = lane_data_i;
  assign en_o     = lane_en_i;

endmodule : tlelm_lane

// ==== tlelm_mapper.sv ====
`timescale 1ns/1ps
// True little-endian byte lane mapper from a 64-bit processor bus to PCI dwords.
module tlelm_mapper
  import tlelm_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    nrst_i,
  input  wire logic [1:0]              endian_mode_i,
  input  wire logic                    req_i,
  input  wire logic [TLELM_ADDR_W-1:0] processor_address_bus_i,
  input  wire logic [TLELM_SZ_W-1:0]   size_i,
  input  wire logic [63:0]             data_i,
  output logic                         busy_o,
  output logic                         pci_valid_o,
  output logic                         pci_a2_o,
  output logic [3:0]                   pci_be_o,
  output logic [31:0]                  pci_data_o,
  output logic                         four_byte_read_en_o
);

  // ==========================================================================
  // Lane enables from start address and size
  // ==========================================================================
  logic [7:0]  lane_en;
  logic [15:0] en_wide;
  logic        true_le;

  assign true_le = (endian_mode_i == TLELM_END_TRUE_LE);
  assign en_wide = {8'h00, 8'hFF >> (4'(TLELM_LANES) - size_i)}
                   << processor_address_bus_i;
  assign lane_en = (size_i == 4'h0) ? 8'h00 : en_wide[7:0];

  // ==========================================================================
  // Lane steering
  // ==========================================================================
  logic [7:0]  l_dw;
  logic [15:0] l_pos;
  logic [63:0] l_data;
  logic [7:0]  l_en;

  genvar k;
  generate
    for (k = 0; k < TLELM_LANES; k++)
    begin : g_lane
      tlelm_lane #(.LANE(k)) u_lane (
        .lane_data_i (data_i[63-8*k -: 8]),
        .lane_en_i   (lane_en[k]),
        .dw_sel_o    (l_dw[k]),
        .pos_o       (l_pos[2*k +: 2]),
        .data_o      (l_data[8*k +: 8]),
        .en_o        (l_en[k])
      );
    end
  endgenerate

  // Packs each half into its own PCI dword; byte position p sits at bits 8p.
  logic [31:0] lo_data_nxt;
  logic [31:0] hi_data_nxt;
  logic [3:0]  lo_be_nxt;
  logic [3:0]  hi_be_nxt;

  always_comb
  begin
    lo_data_nxt = TLELM_DATA_RST;
    hi_data_nxt = TLELM_DATA_RST;
    lo_be_nxt   = TLELM_PBE_RST;
    hi_be_nxt   = TLELM_PBE_RST;
    for (int i = 0; i < TLELM_LANES; i++)
    begin
      if (l_dw[i])
      begin
        hi_data_nxt[8*l_pos[2*i +: 2] +: 8] = l_data[8*i +: 8];
        hi_be_nxt[l_pos[2*i +: 2]]          = l_en[i];
      end
      else
      begin
        lo_data_nxt[8*l_pos[2*i +: 2] +: 8] = l_data[8*i +: 8];
        lo_be_nxt[l_pos[2*i +: 2]]          = l_en[i];
      end
    end
  end

  // ==========================================================================
  // Dword sequencer
  // ==========================================================================
  tlelm_state_t state_r;
  logic [31:0]  hi_data_r;
  logic [3:0]   hi_be_r;
  logic         accept;

  assign accept = req_i && (state_r == TLELM_IDLE) && true_le;

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      state_r <= TLELM_IDLE;
    else
    begin
      unique case (state_r)
        TLELM_IDLE:
          if (accept && (lo_be_nxt != 4'h0) && (hi_be_nxt != 4'h0))
            state_r <= TLELM_HIGH;
        TLELM_HIGH:
          state_r <= TLELM_IDLE;
        default:
          state_r <= TLELM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      hi_data_r <= TLELM_DATA_RST;
      hi_be_r   <= TLELM_PBE_RST;
    end
    else if (accept)
    begin
      hi_data_r <= hi_data_nxt;
      hi_be_r   <= hi_be_nxt;
    end
  end

  // ==========================================================================
  // PCI outputs
  // ==========================================================================
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      pci_valid_o <= 1'b0;
      pci_a2_o    <= 1'b0;
      pci_be_o    <= TLELM_PBE_RST;
      pci_data_o  <= TLELM_DATA_RST;
    end
    else if (state_r == TLELM_HIGH)
    begin
      pci_valid_o <= 1'b1;
      pci_a2_o    <= 1'b1;
      pci_be_o    <= hi_be_r;
      pci_data_o  <= hi_data_r;
    end
    else if (accept && (lo_be_nxt != 4'h0))
    begin
      pci_valid_o <= 1'b1;
      pci_a2_o    <= 1'b0;
      pci_be_o    <= lo_be_nxt;
      pci_data_o  <= lo_data_nxt;
    end
    else if (accept)
    begin
      pci_valid_o <= 1'b1;
      pci_a2_o    <= 1'b1;
      pci_be_o    <= hi_be_nxt;
      pci_data_o  <= hi_data_nxt;
    end
    else
      pci_valid_o <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      busy_o              <= 1'b0;
      four_byte_read_en_o <= 1'b0;
    end
    else
    begin
      busy_o              <= accept && (lo_be_nxt != 4'h0) && (hi_be_nxt != 4'h0);
      four_byte_read_en_o <= !true_le;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_split_high_second: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (pci_valid_o && !pci_a2_o && busy_o) |=> (pci_valid_o && pci_a2_o))
    else $error("Second dword of a split transfer missing.");

  a_four_byte_off: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    true_le |=> !four_byte_read_en_o)
    else $error("Four-byte read enabled in true little-endian.");

  a_four_byte_on: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !true_le |=> four_byte_read_en_o)
    else $error("Four-byte read disabled in another mode.");

  a_byte0_to_top: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (accept && size_i == 4'h1 && processor_address_bus_i == 3'h0)
      |=> (pci_be_o == 4'h8 && !pci_a2_o && pci_data_o[31:24] == $past(data_i[63:56])))
    else $error("Lane 0 not on top byte of low dword.");

  a_byte7_to_low: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (accept && size_i == 4'h1 && processor_address_bus_i == 3'h7)
      |=> (pci_be_o == 4'h1 && pci_a2_o && pci_data_o[7:0] == $past(data_i[7:0])))
    else $error("Lane 7 not on low byte of high dword.");

  a_double_data: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (accept && size_i == 4'h8 && processor_address_bus_i == 3'h0)
      |=> (pci_data_o == $past(data_i[63:32]) && pci_be_o == 4'hF)
          ##1 (pci_data_o == $past(data_i[31:0], 2) && pci_a2_o))
    else $error("Double transfer data not invariant.");

  a_no_accept_busy: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    busy_o |-> (state_r == TLELM_HIGH))
    else $error("Busy without a pending high dword.");

  a_mode_gate: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (state_r == TLELM_IDLE && !accept) |=> !pci_valid_o)
    else $error("PCI access issued without an accepted request.");

endmodule : tlelm_mapper

// ==== tlelm_mapper_tb_top.sv ====
`timescale 1ns/1ps
// Self-checking bench for the true little-endian lane mapper.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tlelm_mapper_tb_top;
  import tlelm_pkg::*;
  logic        clk_sys_i, nrst_i, req_i, busy_o, pci_valid_o, pci_a2_o, fbr_o;
  logic [1:0]  endian_mode_i;
  logic [2:0]  addr_i;
  logic [3:0]  size_i, pci_be_o;
  logic [63:0] data_i;
  logic [31:0] pci_data_o;
  logic [7:0]  n_dw;
  int          n_fail, n_checks, n_exp, cyc;

  tlelm_mapper u_tlelm_mapper (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .endian_mode_i(endian_mode_i), .req_i(req_i), .processor_address_bus_i(addr_i),
    .size_i(size_i), .data_i(data_i), .busy_o(busy_o), .pci_valid_o(pci_valid_o),
    .pci_a2_o(pci_a2_o), .pci_be_o(pci_be_o), .pci_data_o(pci_data_o),
    .four_byte_read_en_o(fbr_o));
  tlelm_pci_tgt u_tlelm_pci_tgt (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .valid_i(pci_valid_o), .n_dw_o(n_dw));

  // ==========================================================================
  // Clock, timeout and closing report
  // ==========================================================================
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      test_done();
    end
  end

  // Sends one request and judges every dword it produces.
  task automatic xfer(input logic [2:0] a, input logic [3:0] sz, input logic [63:0] d);
    logic [3:0]  be [2];
    logic [31:0] dw [2];
    logic [31:0] m [2];
    int          k, p;
    be = '{4'h0, 4'h0};
    dw = '{32'h0, 32'h0};
    m = '{32'h0, 32'h0};
    for (k = a; k < a + sz && k < 8; k++)
    begin
      p = 3 - k % 4;
      be[k/4][p] = 1'b1;
      m[k/4][8*p +: 8] = 8'hFF;
      dw[k/4][8*p +: 8] = d[63-8*k -: 8];
    end
    req_i = 1'b1;
    addr_i = a;
    size_i = sz;
    data_i = d;
    @(posedge clk_sys_i);
    #1 req_i = 1'b0;
    for (k = 0; k < 2; k++)
      if (be[k] != 4'h0)
      begin
        n_exp++;
        `CHK(pci_valid_o, 1'b1)
        `CHK(busy_o, k == 0 && be[1] != 4'h0)
        `CHK(pci_a2_o, k[0])
        `CHK(pci_be_o, be[k])
        `CHK(pci_data_o & m[k], dw[k])
        @(posedge clk_sys_i);
        #1;
      end
    `CHK(pci_valid_o, 1'b0)
  endtask : xfer

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    {nrst_i, req_i, addr_i, size_i, data_i} = '0;
    endian_mode_i = TLELM_END_TRUE_LE;
    repeat (12) @(posedge clk_sys_i);
    #1 `CHK(({busy_o, pci_valid_o, pci_be_o}), 6'h00)
    nrst_i = 1'b1;
    @(posedge clk_sys_i);
    #1 `CHK(fbr_o, 1'b0)
    for (int s = 1; s <= 8; s++)
      for (int a = 0; a + s <= 8; a++)
        xfer(a[2:0], s[3:0], 64'hD0D1_D2D3_D4D5_D6D7 ^ {8{s[3:0], a[3:0]}});
    for (int md = 0; md < 3; md++)
    begin
      endian_mode_i = md[1:0];
      req_i = 1'b1;
      @(posedge clk_sys_i);
      #1 req_i = 1'b0;
      `CHK(fbr_o, 1'b1)
      `CHK(pci_valid_o, 1'b0)
    end
    endian_mode_i = TLELM_END_TRUE_LE;
    @(posedge clk_sys_i);
    #1 `CHK(fbr_o, 1'b0)
    `CHK(n_dw, n_exp[7:0])
    // Mid-run reset, then a split request at the first edge after release.
    nrst_i = 1'b0;
    @(posedge clk_sys_i);
    #1 `CHK(({busy_o, pci_valid_o, fbr_o}), 3'h0)
    nrst_i = 1'b1;
    xfer(3'h3, 4'h5, 64'h0123_4567_89AB_CDEF);
    test_done();
  end
endmodule : tlelm_mapper_tb_top

// ==== tlelm_pci_tgt.sv ====
`timescale 1ns/1ps
// PCI target model that counts the dword accesses it receives.
module tlelm_pci_tgt (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       valid_i,
  output logic      [7:0] n_dw_o
);
  // ==========================================================================
  // Access counter
  // ==========================================================================
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      n_dw_o <= 8'h00;
    else if (valid_i)
      n_dw_o <= n_dw_o + 8'h01;
  end
endmodule : tlelm_pci_tgt

// ==== tlelm_pkg.sv ====
// Constants and types for the true little-endian lane mapper.
// Operation
// - True little-endian keeps each byte's significance; only byte addressing changes.
// - No address bits are swapped between processor and PCI in true little-endian.
// - Processor lowest-address byte lands on the highest PCI byte position.
// - Four-byte read mechanism is disabled while true little-endian is active.
// - Four-byte read mechanism stays available in every other endian mode.
// - Lane k goes to dword k/4 and byte position 3 minus k mod 4.
package tlelm_pkg;

  // ==========================================================================
  // Endian mode encodings
  // ==========================================================================
  localparam logic [1:0] TLELM_END_TRUE_LE = 2'h3;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int TLELM_LANES    = 8;
  localparam int TLELM_DW_LANES = 4;
  localparam int TLELM_SZ_W     = 4;
  localparam int TLELM_ADDR_W   = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]  TLELM_BE_RST   = 8'h00;
  localparam logic [3:0]  TLELM_PBE_RST  = 4'h0;
  localparam logic [31:0] TLELM_DATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    TLELM_IDLE = 2'b00,
    TLELM_HIGH = 2'b01
  } tlelm_state_t;

endpackage : tlelm_pkg
